// ---- rtl/gpio_pin_config.sv ----
/*
 * shared-pin gpio configuration: connect, direction and level
 * registers behind a classic wishbone slave, plus the pin drivers.
 * assumes the analog switch fabric acts on analog_link_o and that the
 * pad resolves the wire from pin_out_o and pin_oe_n_o.
 */
`timescale 1ns/1ps
module gpio_pin_config (
    // clock and reset
    input  wire logic                                clk_i,
    input  wire logic                                rst_i,
    // wishbone slave
    input  wire logic                                cyc_i,
    input  wire logic                                stb_i,
    input  wire logic                                we_i,
    input  wire logic [gpio_pin_pkg::ADR_W-1:0]      adr_i,
    input  wire logic [3:0]                          sel_i,
    input  wire logic [gpio_pin_pkg::DATA_W-1:0]     dat_i,
    output      logic [gpio_pin_pkg::DATA_W-1:0]     dat_o,
    output      logic                                ack_o,
    // gpio pads
    input  wire logic [gpio_pin_pkg::PINS-1:0]       pin_in_i,
    output      logic [gpio_pin_pkg::PINS-1:0]       pin_out_o,
    output      logic [gpio_pin_pkg::PINS-1:0]       pin_oe_n_o,
    // analog switch controls: bits 0..6 to inputs 3..9, bit 7 to common
    output      logic [gpio_pin_pkg::PINS-1:0]       analog_link_o
);
    localparam int unsigned N = gpio_pin_pkg::PINS;
    localparam int unsigned W = gpio_pin_pkg::DATA_W;

    logic [N-1:0] connect_reg;
    logic [N-1:0] connect_next;
    logic [N-1:0] direction_reg;
    logic [N-1:0] direction_next;
    logic [N-1:0] level_reg;
    logic [N-1:0] level_next;
    logic         ack_reg;
    logic         ack_next;
    logic [W-1:0] rdata_reg;
    logic [W-1:0] rdata_next;
    logic [N-1:0] pin_out_reg;
    logic [N-1:0] pin_out_next;
    logic [N-1:0] oe_n_reg;
    logic [N-1:0] oe_n_next;
    logic [N-1:0] link_reg;
    logic [N-1:0] link_next;
    logic [N-1:0] level_view;
    logic [gpio_pin_pkg::IDX_W-1:0] idx;
    logic         req;
    logic         wr_lane0;

    pin_sense_if sense ();

    // pin levels pass the three-stage sampler
    pin_sync u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sense (sense.sampler)
    );

    assign sense.raw = pin_in_i;
    assign idx       = adr_i[gpio_pin_pkg::IDX_LSB +: gpio_pin_pkg::IDX_W];
    assign req       = cyc_i & stb_i;
    // write lands on the edge where ack is high
    assign wr_lane0  = req & we_i & ack_reg & sel_i[0];

    // readable level: inputs show the pin, outputs read zero
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_lvl
            always_comb begin
                level_view[g] = direction_reg[g] & sense.settled[g];
            end
        end
    endgenerate

    // register file next values and bus answer
    always_comb begin
        connect_next   = connect_reg;
        direction_next = direction_reg;
        level_next     = level_reg;
        ack_next       = req & ~ack_reg;
        rdata_next     = rdata_reg;
        if (wr_lane0) begin
            unique case (idx)
                gpio_pin_pkg::IDX_CONNECT:   connect_next   = dat_i[N-1:0];
                gpio_pin_pkg::IDX_DIRECTION: direction_next = dat_i[N-1:0];
                gpio_pin_pkg::IDX_LEVEL:     level_next     = dat_i[N-1:0];
                default: ;
            endcase
        end
        if (req & ~ack_reg) begin
            rdata_next = '0;
            unique case (idx)
                gpio_pin_pkg::IDX_CONNECT:
                    rdata_next[N-1:0] = connect_reg;
                gpio_pin_pkg::IDX_DIRECTION:
                    rdata_next[N-1:0] = direction_reg;
                gpio_pin_pkg::IDX_LEVEL:
                    rdata_next[N-1:0] = level_view;
                default: ;                          // unmapped reads zero
            endcase
        end
    end

    // pad and switch drive from the stored configuration
    always_comb begin
        link_next    = connect_reg;
        pin_out_next = level_reg;
        oe_n_next    = ~(connect_reg & ~direction_reg);
    end

    // registers; reset clears all but oe_n_reg, which is set to all ones so the pads are released
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            connect_reg   <= gpio_pin_pkg::CONNECT_RST;
            direction_reg <= gpio_pin_pkg::DIRECTION_RST;
            level_reg     <= gpio_pin_pkg::LEVEL_RST;
            ack_reg       <= 1'b0;
            rdata_reg     <= '0;
            pin_out_reg   <= gpio_pin_pkg::LEVEL_RST;
            oe_n_reg      <= '1;
            link_reg      <= gpio_pin_pkg::CONNECT_RST;
        end else begin
            connect_reg   <= connect_next;
            direction_reg <= direction_next;
            level_reg     <= level_next;
            ack_reg       <= ack_next;
            rdata_reg     <= rdata_next;
            pin_out_reg   <= pin_out_next;
            oe_n_reg      <= oe_n_next;
            link_reg      <= link_next;
        end
    end

    assign dat_o         = rdata_reg;
    assign ack_o         = ack_reg;
    assign pin_out_o     = pin_out_reg;
    assign pin_oe_n_o    = oe_n_reg;
    assign analog_link_o = link_reg;
endmodule

// ---- rtl/gpio_pin_pkg.sv ----
/*
 * constants for the shared-pin gpio configuration block: register
 * indices, reset values and bus widths.
 * assumes a 32-bit classic wishbone bus with word-aligned registers.
 */
package gpio_pin_pkg;
    localparam int unsigned PINS      = 8;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned ADR_W     = 8;
    localparam int unsigned IDX_W     = 6;
    localparam int unsigned SYNC_LEN  = 3;
    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CONNECT   = 6'h12;
    localparam logic [IDX_W-1:0] IDX_DIRECTION = 6'h13;
    localparam logic [IDX_W-1:0] IDX_LEVEL     = 6'h14;
    localparam int unsigned      IDX_LSB       = 2;
    // reset values
    localparam logic [PINS-1:0] CONNECT_RST   = 8'h00;
    localparam logic [PINS-1:0] DIRECTION_RST = 8'h00;
    localparam logic [PINS-1:0] LEVEL_RST     = 8'h00;
    localparam logic [PINS-1:0] PIN_IN_RST    = 8'h00;
endpackage

// ---- rtl/pin_sense_if.sv ----
/*
 * interface carrying raw pin levels into the synchroniser and the
 * settled levels back out to the register logic.
 * assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
interface pin_sense_if;
    logic [gpio_pin_pkg::PINS-1:0] raw;
    logic [gpio_pin_pkg::PINS-1:0] settled;
    modport sampler (input raw, output settled);
    modport user    (output raw, input settled);
endinterface

// ---- rtl/pin_sync.sv ----
/*
 * three-stage sampler for the external pin levels; a level counts
 * once the second and third stages agree.
 * assumes pins are asynchronous to clk_i.
 */
`timescale 1ns/1ps
module pin_sync (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // pins in, settled levels out
    pin_sense_if.sampler    sense
);
    localparam int unsigned N = gpio_pin_pkg::PINS;

    logic [N-1:0] s1_reg;
    logic [N-1:0] s2_reg;
    logic [N-1:0] s3_reg;
    logic [N-1:0] held_reg;
    logic [N-1:0] held_next;

    // per pin: take the new level only when stages two and three match
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pin
            always_comb begin
                held_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g]
                                                         : held_reg[g];
            end
        end
    endgenerate

    // shift chain; first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_reg   <= gpio_pin_pkg::PIN_IN_RST;
            s2_reg   <= gpio_pin_pkg::PIN_IN_RST;
            s3_reg   <= gpio_pin_pkg::PIN_IN_RST;
            held_reg <= gpio_pin_pkg::PIN_IN_RST;
        end else begin
            s1_reg   <= sense.raw;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            held_reg <= held_next;
        end
    end

    assign sense.settled = held_reg;
endmodule

// ---- test/gpio_pin_config_assertions.sv ----
/*
 * concurrent checks on the ports of the gpio pin configuration block.
 * assumes a bind from the bench and the single clock clk_i.
 */
`timescale 1ns/1ps
module gpio_pin_config_assertions (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // wishbone slave
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // pads and analog switches
    input wire logic [7:0]  pin_in_i,
    input wire logic [7:0]  pin_out_o,
    input wire logic [7:0]  pin_oe_n_o,
    input wire logic [7:0]  analog_link_o
);
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // request taken, and a write accepted at its ack edge
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_wr(a);
        ack_o && cyc_i && stb_i && we_i && sel_i[0] && adr_i == a;
    endsequence
    // bus handshake
    a_ack_answer: assert property (s_req |=> ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    // register writes reach the pads one cycle after the register
    a_link_copy: assert property (s_wr(8'h48) |=> ##1
        analog_link_o == $past(dat_i[7:0], 2)) else $error("link wrong");
    a_dir_sets_oe: assert property (s_wr(8'h4c) |=> ##1
        pin_oe_n_o == ~(analog_link_o & ~$past(dat_i[7:0], 2)))
        else $error("direction not applied");
    a_level_drive: assert property (s_wr(8'h50) |=> ##1
        pin_out_o == $past(dat_i[7:0], 2)) else $error("level not driven");
    a_drive_gate: assert property ((~pin_oe_n_o & ~analog_link_o) == 8'h00)
        else $error("pin driven while unlinked");
    a_nosel_hold: assert property (ack_o && we_i && !sel_i[0]
        |=> ##1 $stable(analog_link_o) && $stable(pin_oe_n_o))
        else $error("write without low lane took effect");
    a_read_zero: assert property (s_req and (!we_i && adr_i[7:2] > 6'h14)
        |=> dat_o == 32'h0000_0000) else $error("unmapped read not zero");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o &&
        analog_link_o == 8'h00 && pin_oe_n_o == 8'hff)
        else $error("reset state wrong");
endmodule

// ---- test/gpio_pin_config_bench.sv ----
/*
 * self-checking bench: walking-bit and random register traffic over
 * wishbone, pad levels, dropped writes and a mid-run reset.
 * assumes the checker module is compiled before this file.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module gpio_pin_config_bench;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic        ack_o;
    logic [7:0]  adr_i = 8'h00, pin_in_i = 8'h00;
    logic [3:0]  sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o, rd;
    logic [7:0]  pin_out_o, pin_oe_n_o, analog_link_o, c, d, v, p;
    int          fails = 0, n_checks = 0, seed = 32'h74ab6e79, i;
    // 100 ns clock
    always #50 clk_i = ~clk_i;
    gpio_pin_config u_dut (.*);
    // counts and verdict
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // one classic cycle, ack awaited under a bound
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] wd);
        int k;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= {24'h00_0000, wd};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 16);
        rd = dat_o;
        if (ack_o !== 1'b1) begin
            fails++;
            end_sim;
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // reset, walking bits, random traffic, reset again mid-run
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (i = 0; i < 30; i++) begin
            if (i == 20) begin
                rst_i <= 1'b1;
                @(posedge clk_i);
                rst_i <= 1'b0;
                @(posedge clk_i);
            end
            if (i == 0 || i == 20) begin
                `CHK("oe reset", 8'hff, pin_oe_n_o)
                wb(1'b0, 8'h48, 8'h00);
                `CHK("connect reset", 8'h00, rd[7:0])
                wb(1'b0, 8'h4c, 8'h00);
                `CHK("direction reset", 8'h00, rd[7:0])
            end
            c = (i < 8) ? 8'h01 << i : 8'($random(seed));
            d = 8'($random(seed));
            v = 8'($random(seed));
            p = 8'($random(seed));
            pin_in_i <= p;
            wb(1'b1, 8'h48, c);
            wb(1'b1, 8'h4c, d);
            wb(1'b1, 8'h50, v);
            wb(1'b1, 8'h54, 8'hff);  // unmapped, dropped
            sel_i <= 4'he;
            wb(1'b1, 8'h48, ~c);     // low lane off, dropped
            sel_i <= 4'hf;
            wb(1'b0, 8'h48, 8'h00);
            `CHK("connect", c, rd[7:0])
            wb(1'b0, 8'h4c, 8'h00);
            `CHK("direction", d, rd[7:0])
            wb(1'b0, 8'h54, 8'h00);
            `CHK("unmapped", 32'h0000_0000, rd)
            wb(1'b0, 8'h50, 8'h00);
            `CHK("level read", p & d, rd[7:0])
            `CHK("link", c, analog_link_o)
            `CHK("oe", ~(c & ~d), pin_oe_n_o)
            `CHK("level out", v, pin_out_o)
        end
        end_sim;
    end
endmodule
bind gpio_pin_config gpio_pin_config_assertions u_chk (.*);
